// ---- test/hcd_fetch_model.sv ----
// Purpose: fetch side that offers instruction words to the decoder
// Assumes: callers invoke the tasks right after a rising edge
// Notes: idle cycles scramble word and pc so held fields cannot hide
`timescale 1ns/1ps
module hcd_fetch_model (
   output logic fetch_valid,
   output logic [15:0] fetch_word,
   output logic [15:0] fetch_pc,
   output logic [15:0] stack_ptr
);
   initial begin
      fetch_valid = 1'b0;
      fetch_word = 16'h0000;
      fetch_pc = 16'h0000;
      stack_ptr = 16'h0000;
   end
   task automatic offer(input logic [15:0] w, input logic [15:0] pc, input logic [15:0] sp);
      fetch_valid <= 1'b1;
      fetch_word <= w;
      fetch_pc <= pc;
      stack_ptr <= sp;
   endtask
   // no stale word on the bus between offers
   task automatic idle();
      fetch_valid <= 1'b0;
      fetch_word <= ~fetch_word;
      fetch_pc <= ~fetch_pc;
      stack_ptr <= ~stack_ptr;
   endtask
endmodule

// ---- test/tb.sv ----
// Purpose: self-checking bench for the instruction word decoder
// Assumes: 200 MHz clock, one-cycle decode latency
// Notes: reset reads, word table, then registers, fields and a second reset by hand
`timescale 1ns/1ps
module tb;
   localparam int NROW = 47;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd_data;
   logic pready, pslverr, rd_err, fetch_valid, dec_valid, dec_unimpl, sel_core, sel_io, sel_math;
   logic [15:0] fetch_word, fetch_pc, stack_ptr, mem_eff_addr, skip_target;
   hcd_pkg::hcd_class_type dec_class;
   hcd_pkg::hcd_op_type dec_op;
   logic mem_indirect, mem_current_page, mem_is_reg, ab_sel, skip_invert, ret_pop, compl_ones;
   logic alter_change, alter_set, stk_byte, stk_decrement, stk_withdraw, stk_ptr_d, stk_adjust_before;
   logic stk_byte_left;
   logic [3:0] mem_opcode;
   logic [9:0] mem_addr_field;
   logic [1:0] shift_type, skip_cond;
   logic [4:0] shift_count, exe_reg, block_count;
   logic [5:0] ret_offset;
   logic [2:0] stk_reg;
   logic [35:0] r;
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   // word, class, op ordinal
   logic [35:0] rows [0:NROW-1] = '{
      36'h0000_001_00, 36'he800_001_00, 36'h87ff_001_00, 36'hf10f_002_00, 36'hf9c0_002_00,
      36'h7400_004_00, 36'h7dff_004_00, 36'h7700_008_00, 36'hf400_008_00, 36'hffff_008_00,
      36'hf080_010_00, 36'hf0ff_010_00, 36'hf060_020_00, 36'hf820_020_00, 36'h701f_040_00,
      36'hf000_040_00, 36'h7100_080_01, 36'h7108_080_02, 36'h7140_080_03, 36'h7148_080_04,
      36'h7150_080_05, 36'h7158_080_06, 36'h7110_080_07, 36'h7118_080_08, 36'h7120_080_09,
      36'h7128_080_0a, 36'h7138_080_0b, 36'h7160_100_00, 36'h79ff_100_00, 36'h738f_200_00,
      36'h7300_200_00, 36'h7b00_400_0c, 36'h7b21_400_0d, 36'h7b61_400_0e, 36'h7b40_400_0f,
      36'h7340_400_10, 36'h7280_800_11, 36'h7200_800_12, 36'h7260_800_13, 36'h7220_800_14,
      36'h7a00_800_15, 36'h7a21_800_16, 36'h7b8f_800_17, 36'h73c0_800_18, 36'h7040_000_00,
      36'h7104_000_00, 36'hf200_000_00};

   hcd_fetch_model fm (.fetch_valid, .fetch_word, .fetch_pc, .stack_ptr);
   hcd_decoder uut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .fetch_valid, .fetch_word, .fetch_pc, .stack_ptr, .dec_valid, .dec_class, .dec_op, .dec_unimpl,
      .sel_core, .sel_io, .sel_math, .mem_indirect, .mem_opcode, .mem_current_page, .mem_addr_field,
      .mem_eff_addr, .mem_is_reg, .ab_sel, .shift_type, .shift_count, .skip_target, .skip_cond,
      .skip_invert, .ret_pop, .ret_offset, .compl_ones, .alter_change, .alter_set, .exe_reg, .stk_byte,
      .stk_decrement, .stk_withdraw, .stk_ptr_d, .stk_reg, .stk_adjust_before, .stk_byte_left,
      .block_count);

   always #2.5 clk = ~clk;

   task automatic results();
      if (fails == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails++;
         results();
      end
   end

   task automatic cmp_v(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmp_cls(input logic [11:0] e);
      n_compared++;
      if (dec_class !== hcd_pkg::hcd_class_type'(e)) begin
         fails++;
         $display("wrong value at %0t: class %h expected %h", $time, dec_class, e);
      end
   endtask
   task automatic cmp_op(input logic [4:0] e);
      n_compared++;
      if (dec_op !== hcd_pkg::hcd_op_type'(e)) begin
         fails++;
         $display("wrong value at %0t: op %0d expected %0d", $time, dec_op, e);
      end
   endtask

   // waits for pready however long it takes; only the cycle ceiling ends a hang
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // one word in, idle after it, look once the decode edge has landed
   task automatic dec1(input logic [15:0] w, input logic [15:0] pc, input logic [15:0] sp);
      @(posedge clk);
      fm.offer(w, pc, sp);
      @(posedge clk);
      fm.idle();
      @(negedge clk);
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, hcd_pkg::CTRL_OFS, 32'h0);
      cmp_v(rd_data, {30'h0, hcd_pkg::CTRL_RESET});
      apb(1'b0, hcd_pkg::UNIMPL_CNT_OFS, 32'h0);
      cmp_v(rd_data, 32'h0);
      for (int i = 0; i <= NROW; i++) begin
         @(posedge clk);
         if (i < NROW) fm.offer(rows[i][35:20], 16'h0100, 16'h0000);
         else fm.idle();
         @(negedge clk);
         if (i > 0) begin
            r = rows[i-1];
            cmp_cls(r[19:8]);
            cmp_op(r[4:0]);
            cmp_v({sel_core, sel_io, sel_math, dec_unimpl, dec_valid},
               {|r[14:8], |r[16:15], |r[19:17], r[19:8] == 12'h0, 1'b1});
         end
      end
      apb(1'b0, hcd_pkg::UNIMPL_CNT_OFS, 32'h0);
      cmp_v(rd_data, 32'h3);
      apb(1'b1, hcd_pkg::UNIMPL_CNT_OFS, 32'h0);
      apb(1'b0, hcd_pkg::UNIMPL_CNT_OFS, 32'h0);
      cmp_v(rd_data, 32'h0);
      apb(1'b0, 12'h00c, 32'h0);
      cmp_v(rd_data, 32'h0);
      cmp_v({31'h0, rd_err}, 32'h1);
      apb(1'b1, hcd_pkg::STATUS_OFS, 32'hffffffff);
      apb(1'b0, hcd_pkg::STATUS_OFS, 32'h0);
      cmp_v(rd_data, 32'h0);
      // word held on the fetch side so the status read sees a live class
      @(posedge clk);
      fm.offer(16'h7110, 16'h0000, 16'h0000);
      apb(1'b0, hcd_pkg::STATUS_OFS, 32'h0);
      fm.idle();
      cmp_v(rd_data, 32'h0000_0080);
      dec1(16'h8bff, 16'h1234, 16'h0);
      cmp_v({mem_indirect, mem_opcode, mem_current_page, mem_addr_field}, {1'b1, 4'h1, 1'b0, 10'h3ff});
      cmp_v({mem_eff_addr, mem_is_reg}, {16'hffff, 1'b0});
      dec1(16'h001f, 16'h1234, 16'h0);
      cmp_v({mem_eff_addr, mem_is_reg}, {16'h001f, 1'b1});
      dec1(16'h0020, 16'h1234, 16'h0);
      cmp_v({mem_eff_addr, mem_is_reg}, {16'h0020, 1'b0});
      dec1(16'h0405, 16'h1234, 16'h0);
      cmp_v(mem_eff_addr, 16'h1205);
      dec1(16'h0600, 16'h1234, 16'h0);
      cmp_v(mem_eff_addr, 16'h1000);
      apb(1'b1, hcd_pkg::CTRL_OFS, 32'h3);
      dec1(16'h05ff, 16'h1234, 16'h0);
      cmp_v(mem_eff_addr, 16'h1433);
      dec1(16'h0600, 16'h1234, 16'h0);
      cmp_v(mem_eff_addr, 16'h1034);
      dec1(16'h7405, 16'h0100, 16'h0);
      cmp_v(skip_target, 16'h0105);
      dec1(16'h7420, 16'h0100, 16'h0);
      cmp_v(skip_target, 16'h00e0);
      dec1(16'h7dff, 16'h0100, 16'h0);
      cmp_v({ab_sel, skip_cond, skip_invert}, {1'b1, 2'h3, 1'b1});
      dec1(16'hf10f, 16'h0, 16'h0);
      cmp_v({ab_sel, shift_type, shift_count}, {1'b0, 2'h0, 5'h10});
      dec1(16'hf9c0, 16'h0, 16'h0);
      cmp_v({ab_sel, shift_type, shift_count}, {1'b1, 2'h3, 5'h01});
      dec1(16'hf0ff, 16'h0, 16'h0);
      cmp_v({ret_pop, ret_offset}, {1'b1, 6'h3f});
      dec1(16'hf060, 16'h0, 16'h0);
      cmp_v(compl_ones, 1'b1);
      dec1(16'hf820, 16'h0, 16'h0);
      cmp_v(compl_ones, 1'b0);
      dec1(16'h77c5, 16'h0100, 16'h0);
      cmp_v({alter_change, alter_set, skip_target}, {1'b1, 1'b1, 16'h0105});
      dec1(16'hf01f, 16'h0, 16'h0);
      cmp_v({exe_reg, mem_indirect}, {5'h1f, 1'b1});
      dec1(16'h79ff, 16'h0, 16'h0001);
      cmp_v({stk_byte, stk_decrement, stk_withdraw, stk_ptr_d, stk_reg, stk_adjust_before, stk_byte_left},
         {4'hf, 3'h7, 1'b0, 1'b1});
      dec1(16'h7160, 16'h0, 16'h8000);
      cmp_v({stk_byte, stk_withdraw, stk_reg, stk_adjust_before, stk_byte_left}, 7'h02);
      dec1(16'h738f, 16'h0, 16'h0);
      cmp_v(block_count, 5'h10);
      dec1(16'h7300, 16'h0, 16'h0);
      cmp_v(block_count, 5'h01);
      apb(1'b1, hcd_pkg::CTRL_OFS, 32'h0);
      dec1(16'h7100, 16'h0, 16'h0);
      cmp_v({dec_unimpl, sel_core, sel_io, sel_math}, 4'h8);
      dec1(16'h7960, 16'h0, 16'h8000);
      cmp_v(stk_byte_left, 1'b1);
      apb(1'b0, hcd_pkg::UNIMPL_CNT_OFS, 32'h0);
      cmp_v(rd_data, 32'h1);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      cmp_v({dec_valid, mem_eff_addr, stk_byte_left}, 18'h0);
      apb(1'b0, hcd_pkg::CTRL_OFS, 32'h0);
      cmp_v(rd_data, {30'h0, hcd_pkg::CTRL_RESET});
      results();
   end
endmodule

// ---- verilog/hcd_decoder.sv ----
// Purpose: registered decoder for the three-unit instruction set
// Assumes: one word per cycle on fetch_valid, synchronous inputs
// Notes: results appear one clock after the word is offered
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module hcd_decoder (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_word,
   input wire logic [15:0] fetch_pc,
   input wire logic [15:0] stack_ptr,
   output logic dec_valid,
   output hcd_pkg::hcd_class_type dec_class,
   output hcd_pkg::hcd_op_type dec_op,
   output logic dec_unimpl,
   output logic sel_core,
   output logic sel_io,
   output logic sel_math,
   output logic mem_indirect,
   output logic [3:0] mem_opcode,
   output logic mem_current_page,
   output logic [9:0] mem_addr_field,
   output logic [15:0] mem_eff_addr,
   output logic mem_is_reg,
   output logic ab_sel,
   output logic [1:0] shift_type,
   output logic [4:0] shift_count,
   output logic [15:0] skip_target,
   output logic [1:0] skip_cond,
   output logic skip_invert,
   output logic ret_pop,
   output logic [5:0] ret_offset,
   output logic compl_ones,
   output logic alter_change,
   output logic alter_set,
   output logic [4:0] exe_reg,
   output logic stk_byte,
   output logic stk_decrement,
   output logic stk_withdraw,
   output logic stk_ptr_d,
   output logic [2:0] stk_reg,
   output logic stk_adjust_before,
   output logic stk_byte_left,
   output logic [4:0] block_count
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] page_off(input logic [9:0] a);
      if (a[9]) begin
         page_off = 16'h0000 - {6'h00, {1'b0, ~a[8:0]} + 10'h001};
      end else begin
         page_off = {7'h00, a[8:0]};
      end
   endfunction

   function automatic logic [15:0] skip_tgt(input logic [15:0] p, input logic [5:0] f);
      if (f[5]) begin
         skip_tgt = p - {10'h000, {1'b0, ~f[4:0]} + 6'h01};
      end else begin
         skip_tgt = p + {11'h000, f[4:0]};
      end
   endfunction

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   logic [1:0] ctrl_reg;
   logic [15:0] unimpl_cnt_reg;
   logic var16;
   logic rel_mode;
   logic hit_ctrl;
   logic hit_status;
   logic hit_cnt;
   logic apb_wr;
   logic [31:0] rd_mux;

   assign var16 = ctrl_reg[hcd_pkg::CTRL_VAR16_BIT];
   assign rel_mode = ctrl_reg[hcd_pkg::CTRL_REL_BIT];
   assign hit_ctrl = paddr == hcd_pkg::CTRL_OFS;
   assign hit_status = paddr == hcd_pkg::STATUS_OFS;
   assign hit_cnt = paddr == hcd_pkg::UNIMPL_CNT_OFS;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~(hit_ctrl | hit_status | hit_cnt);
   assign apb_wr = psel & penable & pwrite;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= hcd_pkg::CTRL_RESET;
      end else if (apb_wr && hit_ctrl) begin
         ctrl_reg <= pwdata[1:0];
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux = {30'h0, ctrl_reg};
      end else if (hit_status) begin
         rd_mux = {15'h0, dec_unimpl, 4'h0, dec_class};
      end else if (hit_cnt) begin
         rd_mux = {16'h0, unimpl_cnt_reg};
      end
   end

   // read word caught in the setup cycle: prdata comes from a flip-flop and pready still needs no wait
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   // ----------------------------------------
   // classification
   // ----------------------------------------
   hcd_pkg::hcd_class_type cls_next;
   hcd_pkg::hcd_op_type op_next;
   logic [15:0] w;
   logic [15:0] off;
   logic [15:0] eff_next;

   assign w = fetch_word;
   assign off = page_off(w[9:0]);

   always_comb begin
      op_next = hcd_pkg::OP_NONE;
      unique case (w)
         16'h7100: op_next = var16 ? hcd_pkg::OP_DMA_DIR_OUT : hcd_pkg::OP_NONE;
         16'h7108: op_next = var16 ? hcd_pkg::OP_DMA_DIR_IN : hcd_pkg::OP_NONE;
         16'h7140: op_next = var16 ? hcd_pkg::OP_POINTER_LOWER_CLEAR : hcd_pkg::OP_NONE;
         16'h7148: op_next = var16 ? hcd_pkg::OP_POINTER_LOWER_SET : hcd_pkg::OP_NONE;
         16'h7150: op_next = var16 ? hcd_pkg::OP_POINTER_UPPER_CLEAR : hcd_pkg::OP_NONE;
         16'h7158: op_next = var16 ? hcd_pkg::OP_POINTER_UPPER_SET : hcd_pkg::OP_NONE;
         16'h7110: op_next = hcd_pkg::OP_IRQ_ENABLE;
         16'h7118: op_next = hcd_pkg::OP_IRQ_DISABLE;
         16'h7120: op_next = hcd_pkg::OP_DMA_ENABLE;
         16'h7128: op_next = hcd_pkg::OP_PULSE_COUNT;
         16'h7138: op_next = hcd_pkg::OP_DMA_DISABLE;
         16'h7b00: op_next = hcd_pkg::OP_FIRST_MANT_RIGHT;
         16'h7b21: op_next = hcd_pkg::OP_DECIMAL_RIGHT_SHIFT;
         16'h7b61: op_next = hcd_pkg::OP_SECOND_MANT_LEFT;
         16'h7b40: op_next = hcd_pkg::OP_SECOND_MANT_RIGHT;
         16'h7340: op_next = hcd_pkg::OP_NORMALIZE;
         16'h7280: op_next = hcd_pkg::OP_FIXED_ADD;
         16'h7200: op_next = hcd_pkg::OP_MANT_WORD_ADD;
         16'h7260: op_next = hcd_pkg::OP_FIRST_MANT_COMPL;
         16'h7220: op_next = hcd_pkg::OP_SECOND_MANT_COMPL;
         16'h7a00: op_next = hcd_pkg::OP_FAST_MULTIPLY;
         16'h7a21: op_next = hcd_pkg::OP_FAST_DIVIDE;
         16'h7b8f: op_next = hcd_pkg::OP_BINARY_MULTIPLY;
         16'h73c0: op_next = hcd_pkg::OP_CARRY_CLEAR;
         default: op_next = hcd_pkg::OP_NONE;
      endcase
   end

   // order matters: groups that share the 1111 and 0111 prefixes are told apart by bits 10-5
   always_comb begin
      cls_next = hcd_pkg::CL_NONE;
      if (w[14:11] <= hcd_pkg::MEM_OP_LAST) begin
         cls_next = hcd_pkg::CL_MEM;
      end else if (w[15:12] == 4'hf && w[10:8] == 3'h1 && w[5:4] == 2'h0) begin
         cls_next = hcd_pkg::CL_SHIFT;
      end else if (w[15:7] == hcd_pkg::RET_PAT) begin
         cls_next = hcd_pkg::CL_RET;
      end else if (w[15:12] == 4'hf && w[10:7] == 4'h0 && w[5:0] == 6'h20) begin
         cls_next = hcd_pkg::CL_COMPL;
      end else if (w[14:5] == hcd_pkg::EXE_PAT) begin
         cls_next = hcd_pkg::CL_EXE;
      end else if (w[15:12] == 4'h7 && w[10:9] == 2'h2) begin
         cls_next = hcd_pkg::CL_SKIP;
      end else if (w[14:12] == 3'h7 && w[10] && (w[15] || w[9])) begin
         cls_next = hcd_pkg::CL_ALTER;
      end else if (w[15:12] == 4'h7 && w[10:8] == 3'h1 && w[6:5] == 2'h3) begin
         cls_next = hcd_pkg::CL_STACK;
      end else if (w[15:4] == hcd_pkg::CLEAR4_PAT || w[15:4] == hcd_pkg::XFER4_PAT) begin
         cls_next = hcd_pkg::CL_FOUR;
      end else if (op_next >= hcd_pkg::OP_FIXED_ADD) begin
         cls_next = hcd_pkg::CL_ARITH;
      end else if (op_next >= hcd_pkg::OP_FIRST_MANT_RIGHT) begin
         cls_next = hcd_pkg::CL_MANT;
      end else if (op_next != hcd_pkg::OP_NONE) begin
         cls_next = hcd_pkg::CL_IO;
      end
   end

   always_comb begin
      if (!w[10]) begin
         eff_next = off;
      end else if (rel_mode) begin
         eff_next = fetch_pc + off;
      end else begin
         eff_next = {fetch_pc[15:10], 10'h000} + hcd_pkg::PAGE_MID + off;
      end
   end

   // ----------------------------------------
   // output registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dec_valid <= 1'b0;
         dec_class <= hcd_pkg::CL_NONE;
         dec_op <= hcd_pkg::OP_NONE;
         dec_unimpl <= 1'b0;
         sel_core <= 1'b0;
         sel_io <= 1'b0;
         sel_math <= 1'b0;
      end else begin
         dec_valid <= fetch_valid;
         dec_class <= fetch_valid ? cls_next : hcd_pkg::CL_NONE;
         dec_op <= fetch_valid ? op_next : hcd_pkg::OP_NONE;
         dec_unimpl <= fetch_valid && cls_next == hcd_pkg::CL_NONE;
         sel_core <= fetch_valid && (cls_next & 12'h07f) != 12'h000;
         sel_io <= fetch_valid && (cls_next & 12'h180) != 12'h000;
         sel_math <= fetch_valid && (cls_next & 12'he00) != 12'h000;
      end
   end

   // fields are loaded on every offered word; meaningful only for the matching class
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mem_indirect <= 1'b0;
         mem_opcode <= 4'h0;
         mem_current_page <= 1'b0;
         mem_addr_field <= 10'h000;
         mem_eff_addr <= 16'h0000;
         mem_is_reg <= 1'b0;
         ab_sel <= 1'b0;
         shift_type <= 2'h0;
         shift_count <= 5'h00;
         skip_target <= 16'h0000;
         skip_cond <= 2'h0;
         skip_invert <= 1'b0;
         ret_pop <= 1'b0;
         ret_offset <= 6'h00;
         compl_ones <= 1'b0;
         alter_change <= 1'b0;
         alter_set <= 1'b0;
         exe_reg <= 5'h00;
         block_count <= 5'h00;
      end else if (fetch_valid) begin
         mem_indirect <= w[15];
         mem_opcode <= w[14:11];
         mem_current_page <= w[10];
         mem_addr_field <= w[9:0];
         mem_eff_addr <= eff_next;
         mem_is_reg <= eff_next < hcd_pkg::REG_SPACE_END;
         ab_sel <= w[11];
         shift_type <= w[7:6];
         shift_count <= {1'b0, w[3:0]} + 5'h01;
         skip_target <= skip_tgt(fetch_pc, w[5:0]);
         skip_cond <= w[7:6];
         skip_invert <= w[8];
         ret_pop <= w[6];
         ret_offset <= w[5:0];
         compl_ones <= w[6];
         alter_change <= w[7];
         alter_set <= w[6];
         exe_reg <= w[4:0];
         block_count <= {1'b0, w[3:0]} + 5'h01;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stk_byte <= 1'b0;
         stk_decrement <= 1'b0;
         stk_withdraw <= 1'b0;
         stk_ptr_d <= 1'b0;
         stk_reg <= 3'h0;
         stk_adjust_before <= 1'b0;
         stk_byte_left <= 1'b0;
      end else if (fetch_valid) begin
         stk_byte <= w[11];
         stk_decrement <= w[7];
         stk_withdraw <= w[4];
         stk_ptr_d <= w[3];
         stk_reg <= w[2:0];
         stk_adjust_before <= ~w[4];
         stk_byte_left <= w[11] && (var16 ? stack_ptr[0] : stack_ptr[15]);
      end
   end

   // counter saturates so software can tell overflow from wrap
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         unimpl_cnt_reg <= 16'h0000;
      end else if (apb_wr && hit_cnt) begin
         // an unknown word in the clearing cycle still counts
         unimpl_cnt_reg <= {15'h0, dec_unimpl};
      end else if (dec_unimpl && unimpl_cnt_reg != 16'hffff) begin
         unimpl_cnt_reg <= unimpl_cnt_reg + 16'h0001;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_mem_op;
      @(posedge clk) disable iff (!rstn)
      fetch_valid && fetch_word[14:11] <= 4'hd |=> dec_class == hcd_pkg::CL_MEM && sel_core
         && mem_opcode == $past(fetch_word[14:11]);
   endproperty
   a_mem_op: assert property (p_mem_op) else $error("memory word misdecoded");

   property p_base_page;
      @(posedge clk) disable iff (!rstn)
      fetch_valid && !fetch_word[10] && !fetch_word[9] |=> mem_eff_addr == {7'h00, $past(fetch_word[8:0])};
   endproperty
   a_base_page: assert property (p_base_page) else $error("base page address wrong");

   property p_neg_off;
      @(posedge clk) disable iff (!rstn)
      fetch_valid && !fetch_word[10] && fetch_word[9]
         |=> mem_eff_addr + {7'h00, ~$past(fetch_word[8:0])} + 16'h0001 == 16'h0000;
   endproperty
   a_neg_off: assert property (p_neg_off) else $error("negative offset wrong");

   property p_rel_page;
      @(posedge clk) disable iff (!rstn)
      fetch_valid && fetch_word[10] && rel_mode |=> mem_eff_addr - $past(fetch_pc) + 16'h0200
         == {6'h00, ~$past(fetch_word[9]), $past(fetch_word[8:0])};
   endproperty
   a_rel_page: assert property (p_rel_page) else $error("relative page address wrong");

   property p_shift_cnt;
      @(posedge clk) disable iff (!rstn)
      fetch_valid && fetch_word[15:12] == 4'hf && fetch_word[10:8] == 3'h1 && fetch_word[5:4] == 2'h0
         |=> dec_class == hcd_pkg::CL_SHIFT && shift_count == $past(fetch_word[3:0]) + 5'h01;
   endproperty
   a_shift_cnt: assert property (p_shift_cnt) else $error("shift count wrong");

   property p_skip_back;
      @(posedge clk) disable iff (!rstn)
      fetch_valid && fetch_word[5] |=> skip_target + {11'h000, ~$past(fetch_word[4:0])} + 16'h0001
         == $past(fetch_pc);
   endproperty
   a_skip_back: assert property (p_skip_back) else $error("backward skip wrong");

   property p_stack_order;
      @(posedge clk) disable iff (!rstn)
      dec_class == hcd_pkg::CL_STACK |-> stk_adjust_before != stk_withdraw && sel_io && !sel_core;
   endproperty
   a_stack_order: assert property (p_stack_order) else $error("stack adjust order wrong");

   property p_variant;
      @(posedge clk) disable iff (!rstn)
      fetch_valid && fetch_word == 16'h7100 && !var16 |=> dec_unimpl && !sel_io;
   endproperty
   a_variant: assert property (p_variant) else $error("16-bit word accepted in 15-bit mode");

   property p_unimpl;
      @(posedge clk) disable iff (!rstn)
      dec_unimpl |-> !sel_core && !sel_io && !sel_math && dec_class == hcd_pkg::CL_NONE;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unit selected for unknown word");

   property p_block;
      @(posedge clk) disable iff (!rstn)
      fetch_valid && fetch_word[15:4] == 12'h730 |=> sel_math && dec_class == hcd_pkg::CL_FOUR
         && block_count - 5'h01 == {1'b0, $past(fetch_word[3:0])};
   endproperty
   a_block: assert property (p_block) else $error("block count out of range");

   property p_irq;
      @(posedge clk) disable iff (!rstn)
      fetch_valid && fetch_word == 16'h7118 |=> dec_op == hcd_pkg::OP_IRQ_DISABLE
         && dec_class == hcd_pkg::CL_IO && sel_io;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt disable misdecoded");
endmodule

// ---- verilog/hcd_pkg.sv ----
// Purpose: constants and types for the instruction word decoder
// Assumes: 16-bit instruction words, APB register access
// Notes: opcode patterns and register map shared by design and bench
package hcd_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] UNIMPL_CNT_OFS = 12'h008;
   localparam int CTRL_VAR16_BIT = 0;
   localparam int CTRL_REL_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   // ----------------------------------------
   // word patterns
   // ----------------------------------------
   localparam logic [3:0] MEM_OP_LAST = 4'hd;
   localparam logic [15:0] PAGE_MID = 16'h0200;
   localparam logic [15:0] REG_SPACE_END = 16'h0020;
   localparam logic [8:0] RET_PAT = 9'h1e1;
   localparam logic [9:0] EXE_PAT = 10'h380;
   localparam logic [11:0] CLEAR4_PAT = 12'h738;
   localparam logic [11:0] XFER4_PAT = 12'h730;
   // ----------------------------------------
   // decode classes, one-hot
   // ----------------------------------------
   typedef enum logic [11:0] {
      CL_NONE  = 12'h000,
      CL_MEM   = 12'h001,
      CL_SHIFT = 12'h002,
      CL_SKIP  = 12'h004,
      CL_ALTER = 12'h008,
      CL_RET   = 12'h010,
      CL_COMPL = 12'h020,
      CL_EXE   = 12'h040,
      CL_IO    = 12'h080,
      CL_STACK = 12'h100,
      CL_FOUR  = 12'h200,
      CL_MANT  = 12'h400,
      CL_ARITH = 12'h800
   } hcd_class_type;
   // ----------------------------------------
   // fixed-word operations
   // ----------------------------------------
   typedef enum logic [4:0] {
      OP_NONE, OP_DMA_DIR_OUT, OP_DMA_DIR_IN, OP_POINTER_LOWER_CLEAR,
      OP_POINTER_LOWER_SET, OP_POINTER_UPPER_CLEAR, OP_POINTER_UPPER_SET,
      OP_IRQ_ENABLE, OP_IRQ_DISABLE, OP_DMA_ENABLE, OP_PULSE_COUNT, OP_DMA_DISABLE,
      OP_FIRST_MANT_RIGHT, OP_DECIMAL_RIGHT_SHIFT, OP_SECOND_MANT_LEFT,
      OP_SECOND_MANT_RIGHT, OP_NORMALIZE, OP_FIXED_ADD, OP_MANT_WORD_ADD,
      OP_FIRST_MANT_COMPL, OP_SECOND_MANT_COMPL, OP_FAST_MULTIPLY,
      OP_FAST_DIVIDE, OP_BINARY_MULTIPLY, OP_CARRY_CLEAR
   } hcd_op_type;
endpackage
